// ### hdl/wdtps_top.sv
// Watchdog timer with postscaler, AHB-Lite register slave and interrupt.
// Assumes the CPU core drives the clear and sleep pulses on REF_CLK.
//
// Contract
// - Three config bits pick postscale 1:128 to 1:1
// - Config enable runs it, else software enable
// - Software cannot stop a config-enabled watchdog
// - Counts on own oscillator, also in sleep
// - Time-out while awake issues device reset
// - Time-out while asleep wakes, no reset
// - Every time-out clears the expiry flag
// - Clear or sleep restarts count and postscaler
// - Clear zeroes shared prescaler when it is assigned to the watchdog, keeps its assignment
// - Software enable is control bit0, resets 0
// - Sleep restarts watchdog, clears powerdown, sets expiry
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "wdtps_defs.svh"
module wdtps_top
  import wdtps_pkg::*;
#(
  parameter int                BASE_W     = 16,
  parameter logic [BASE_W-1:0] BASE_TICKS = `WDTPS_BASE_TICKS,
  parameter logic [3:0]        CFG_INIT   = `WDTPS_CFG_RESET
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Watchdog oscillator pin
  input  wire logic        WDT_OSC,
  // CPU core events
  input  wire logic        WATCHDOG_CLEAR_INSTR,
  input  wire logic        SLEEP_INSTR,
  input  wire logic        WAKE_EVENT,
  input  wire logic        PRESC_ON_WDT,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Watchdog results
  output logic             WDT_RESET,
  output logic             WDT_WAKE,
  output logic             ASLEEP,
  output logic             PRESC_CLR,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [BASE_W-1:0] ONE       = {{(BASE_W-1){1'b0}}, 1'b1};
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_TICKS - ONE;

  function automatic logic [6:0] post_limit(input wdtps_ps_t sel);
    post_limit = `WDTPS_POST_MAX >> sel;
  endfunction

  wdtps_bus_e        bus_q;
  logic [31:0]       addr_q;
  logic              wr_q;
  logic [31:0]       hrdata_q;
  logic              hready_q;
  logic [3:0]        cfg_q;
  logic              cfg_lock_q;
  logic              sw_on_q;
  logic              expiry_q;
  logic              pwrdn_q;
  logic              asleep_q;
  wdtps_ev_t         ist_q;
  wdtps_ev_t         imask_q;
  logic [BASE_W-1:0] base_q;
  logic [BASE_W-1:0] base_d;
  logic [6:0]        post_q;
  logic [6:0]        post_d;
  logic              rst_out_q;
  logic              wake_out_q;
  logic              presc_clr_q;
  logic              irq_q;
  logic              osc_tick;

  ////////////////////////////////////////////////////////////////////////////
  wdtps_osc_sync u_osc_sync (
    .clk    (REF_CLK),
    .rst_n  (RST_N),
    .osc_in (WDT_OSC),
    .tick   (osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire        accept    = HSEL & HTRANS[1] & HREADY;
  wire        in_data   = (bus_q == WDTPS_BUS_DATA);
  wire        wr_fire   = in_data & wr_q;
  wire        hit_cfg   = (addr_q == `WDTPS_CFG_ADDR);
  wire        hit_ctrl  = (addr_q == `WDTPS_CTRL_ADDR);
  wire        hit_cause = (addr_q == `WDTPS_CAUSE_ADDR);
  wire        hit_istat = (addr_q == `WDTPS_ISTAT_ADDR);
  wire        hit_imask = (addr_q == `WDTPS_IMASK_ADDR);
  wire [3:0]  cause_val = {expiry_q, pwrdn_q, 2'h0};
  // Unmapped addresses read zero and ignore writes
  wire [31:0] rd_data   = hit_cfg   ? {28'h0000000, cfg_q} :
                          hit_ctrl  ? {31'h00000000, sw_on_q} :
                          hit_cause ? {28'h0000000, cause_val} :
                          hit_istat ? {30'h00000000, ist_q} :
                          hit_imask ? {30'h00000000, imask_q} :
                                      32'h0000_0000;

  // Configuration is write-once after reset, as a programmed fuse byte
  wire        cfg_wr    = wr_fire & hit_cfg & ~cfg_lock_q;
  wire        ctrl_wr   = wr_fire & hit_ctrl;
  wire        istat_wr  = wr_fire & hit_istat;
  wire        imask_wr  = wr_fire & hit_imask;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog core
  wire        cfg_on    = cfg_q[`WDTPS_CFG_ON_BIT];
  wire [2:0]  ps_sel    = cfg_q[`WDTPS_PS_MSB:`WDTPS_PS_LSB];
  wire        run       = cfg_on | sw_on_q;
  wire        restart   = WATCHDOG_CLEAR_INSTR | SLEEP_INSTR;
  wire        sleep_go  = SLEEP_INSTR & ~asleep_q;
  wire        base_end  = (base_q == BASE_LAST);
  wire        post_end  = (post_q == post_limit(ps_sel));
  wire        step      = run & osc_tick & ~restart;
  wire        expire    = step & base_end & post_end;
  wire        ev_reset  = expire & ~asleep_q;
  wire        ev_wake   = expire & asleep_q;
  wire [1:0]  events    = {ev_wake, ev_reset};

  // Stopping clears the count so a later start gets a full period
  always_comb begin
    base_d = base_q;
    post_d = post_q;
    if (restart || !run) begin
      base_d = '0;
      post_d = 7'h00;
    end else if (step) begin
      base_d = base_end ? '0 : base_q + ONE;
      if (base_end) begin
        post_d = post_end ? 7'h00 : post_q + 7'h01;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      base_q <= '0;
      post_q <= 7'h00;
    end else begin
      base_q <= base_d;
      post_q <= post_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state, cause flags and output pulses
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      asleep_q    <= 1'b0;
      expiry_q    <= `WDTPS_EXPIRY_RESET;
      pwrdn_q     <= `WDTPS_PWRDN_RESET;
      rst_out_q   <= 1'b0;
      wake_out_q  <= 1'b0;
      presc_clr_q <= 1'b0;
    end else begin
      if (sleep_go) begin
        asleep_q <= 1'b1;
      end else if (ev_wake || WAKE_EVENT) begin
        asleep_q <= 1'b0;
      end
      if (sleep_go) begin
        expiry_q <= 1'b1;
        pwrdn_q  <= 1'b0;
      end else if (expire) begin
        expiry_q <= 1'b0;
      end
      rst_out_q   <= ev_reset;
      wake_out_q  <= ev_wake;
      // Only the count is cleared; the assignment stays with the timer
      presc_clr_q <= WATCHDOG_CLEAR_INSTR & PRESC_ON_WDT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cfg_q      <= CFG_INIT;
      cfg_lock_q <= 1'b0;
      sw_on_q    <= `WDTPS_SW_RESET;
      ist_q      <= 2'h0;
      imask_q    <= 2'h0;
      irq_q      <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cfg_q      <= HWDATA[3:0];
        cfg_lock_q <= 1'b1;
      end
      if (ctrl_wr) begin
        sw_on_q <= HWDATA[`WDTPS_SW_ON_BIT];
      end
      if (imask_wr) begin
        imask_q <= HWDATA[1:0];
      end
      // A new event wins over a write-one-to-clear in the same cycle
      ist_q <= (ist_q & ~(istat_wr ? HWDATA[1:0] : 2'h0)) | events;
      irq_q <= |(ist_q & imask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state so read data comes from a flop
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bus_q    <= WDTPS_BUS_IDLE;
      addr_q   <= 32'h0000_0000;
      wr_q     <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
    end else begin
      case (bus_q)
        WDTPS_BUS_IDLE: begin
          if (accept) begin
            bus_q    <= WDTPS_BUS_DATA;
            addr_q   <= HADDR;
            wr_q     <= HWRITE;
            hready_q <= 1'b0;
          end
        end
        WDTPS_BUS_DATA: begin
          bus_q    <= WDTPS_BUS_IDLE;
          hready_q <= 1'b1;
          if (!wr_q) begin
            hrdata_q <= rd_data;
          end
        end
        default: begin
          bus_q    <= WDTPS_BUS_IDLE;
          hready_q <= 1'b1;
        end
      endcase
    end
  end

  assign HRDATA    = hrdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP     = 1'b0;
  assign WDT_RESET = rst_out_q;
  assign WDT_WAKE  = wake_out_q;
  assign ASLEEP    = asleep_q;
  assign PRESC_CLR = presc_clr_q;
  assign IRQ       = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence timeout_asleep_s;
    expire && asleep_q;
  endsequence

  sequence woke_s;
    WDT_WAKE && !ASLEEP && !WDT_RESET;
  endsequence

  sequence sleep_entry_s;
    sleep_go;
  endsequence

  sequence sleep_state_s;
    asleep_q && expiry_q && !pwrdn_q && base_q == '0 && post_q == 7'h00;
  endsequence

  post_limit_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    expire |-> {1'b0, post_q} + 8'h01 == (8'h80 >> ps_sel) && base_q == BASE_LAST)
    else $error("time-out at wrong postscale count");

  sw_enable_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!cfg_on && !sw_on_q) |=> base_q == '0 && post_q == 7'h00)
    else $error("disabled watchdog kept counting");

  cfg_lock_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (cfg_on && osc_tick && !restart && !base_end) |=>
      base_q == $past(base_q) + ONE)
    else $error("config-enabled watchdog stopped");

  sleep_count_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (asleep_q && step && !base_end) |=> base_q == $past(base_q) + ONE)
    else $error("watchdog did not count during sleep");

  awake_reset_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (expire && !asleep_q) |=> WDT_RESET && !WDT_WAKE ##1 !WDT_RESET)
    else $error("awake time-out gave no single reset pulse");

  sleep_wake_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    timeout_asleep_s |=> woke_s)
    else $error("asleep time-out did not wake cleanly");

  expiry_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    expire |=> !expiry_q)
    else $error("expiry flag not cleared on time-out");

  restart_count_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    restart |=> base_q == '0 && post_q == 7'h00 && !WDT_RESET)
    else $error("clear or sleep did not restart the count");

  presc_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    PRESC_CLR == $past(WATCHDOG_CLEAR_INSTR && PRESC_ON_WDT && RST_N))
    else $error("prescaler clear pulse wrong");

  ctrl_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ctrl_wr |=> sw_on_q == $past(HWDATA[0]) && HREADYOUT)
    else $error("software enable write not taken");

  sleep_flags_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    sleep_entry_s |=> sleep_state_s)
    else $error("sleep entry did not set flags and restart");

  irq_level_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    IRQ == $past(|(ist_q & imask_q) && RST_N))
    else $error("interrupt output does not follow masked status");

endmodule
`default_nettype wire

// ### hdl/wdtps_defs.svh
// Register offsets, field positions and reset values of the watchdog block.
// Assumes a 32-bit AHB-Lite address map with one aligned word per register.
`ifndef WDTPS_DEFS_SVH
`define WDTPS_DEFS_SVH

// Configuration byte sits at word index 0x300003; its byte address is four times that
`define WDTPS_CFG_IDX      32'h0030_0003
`define WDTPS_CFG_ADDR     (`WDTPS_CFG_IDX * 32'h0000_0004)
`define WDTPS_CTRL_ADDR    32'h0000_0000
`define WDTPS_CAUSE_ADDR   32'h0000_0004
`define WDTPS_ISTAT_ADDR   32'h0000_0008
`define WDTPS_IMASK_ADDR   32'h0000_000c

// Field positions
`define WDTPS_CFG_ON_BIT   0
`define WDTPS_PS_LSB       1
`define WDTPS_PS_MSB       3
`define WDTPS_SW_ON_BIT    0
`define WDTPS_EXPIRY_BIT   3
`define WDTPS_PWRDN_BIT    2
`define WDTPS_EV_RESET_BIT 0
`define WDTPS_EV_WAKE_BIT  1

// Reset values
`define WDTPS_CFG_RESET    4'hf
`define WDTPS_SW_RESET     1'h0
`define WDTPS_EXPIRY_RESET 1'h1
`define WDTPS_PWRDN_RESET  1'h1

// Timing counts
`define WDTPS_BASE_TICKS   16'h0400
`define WDTPS_POST_MAX     7'h7f

`endif

// ### hdl/wdtps_pkg.sv
// Types shared by the watchdog block.
// Assumes the defs header is compiled alongside.
package wdtps_pkg;
  typedef enum logic [0:0] {
    WDTPS_BUS_IDLE = 1'b0,
    WDTPS_BUS_DATA = 1'b1
  } wdtps_bus_e;

  typedef logic [2:0] wdtps_ps_t;
  typedef logic [1:0] wdtps_ev_t;
endpackage

// ### hdl/wdtps_osc_sync.sv
// Samples the free-running watchdog RC oscillator and marks its rising edges.
// Assumes the oscillator is well below half the REF_CLK rate.
`timescale 1ns/100ps
`default_nettype none
module wdtps_osc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Oscillator pin
  input  wire logic osc_in,
  // One-cycle pulse per oscillator rising edge
  output logic      tick
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;
  logic tick_q;

  // A change only counts once the second and third stages agree
  assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  assign tick  = tick_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      s1_q   <= osc_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      tick_q <= lvl_d & ~lvl_q;
    end
  end
endmodule
`default_nettype wire

// ### testbench/wdtps_top_test.sv
// Self-checking bench for the watchdog block: periods, enables, sleep, bus, interrupt.
// Assumes the design files and the defs header are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`include "wdtps_defs.svh"
module wdtps_top_test;
  // Short base period keeps the 1:128 row to a few thousand cycles
  localparam int BT = 4;
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ticks;
  } wdtps_row_s;
  wdtps_row_s  rows [8] = '{
    '{32'h1, BT * 128}, '{32'h3, BT * 64}, '{32'h5, BT * 32}, '{32'h7, BT * 16},
    '{32'h9, BT * 8},   '{32'hb, BT * 4},  '{32'hd, BT * 2},  '{32'hf, BT * 1}};

  logic        REF_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        WATCHDOG_CLEAR_INSTR = 1'b0;
  logic        SLEEP_INSTR = 1'b0;
  logic        WAKE_EVENT = 1'b0;
  logic        PRESC_ON_WDT = 1'b0;
  logic        HSEL = 1'b0;
  logic        HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'b00;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT, HRESP, WDT_RESET, WDT_WAKE, ASLEEP, PRESC_CLR, IRQ;
  wire  logic  WDT_OSC;
  logic        osc_run = 1'b1;
  logic [2:0]  osc_ph = 3'h0;
  logic [31:0] edges = 32'h0;
  logic [31:0] npulse = 32'h0;
  logic [31:0] e0, p0;
  int          failures = 0;
  int          cmp_count = 0;

  always #2.5 REF_CLK = ~REF_CLK;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator runs at one eighth of REF_CLK; its rising edges are counted here
  always @(posedge REF_CLK) begin
    if (osc_run) osc_ph <= osc_ph + 3'h1;
    if (osc_run && osc_ph == 3'h3) edges <= edges + 32'h1;
    if (WDT_RESET === 1'b1 || WDT_WAKE === 1'b1) npulse <= npulse + 32'h1;
  end
  assign WDT_OSC = osc_ph[2];

  wdtps_top #(.BASE_TICKS(16'h0004)) i_dut (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .WDT_OSC(WDT_OSC),
    .WATCHDOG_CLEAR_INSTR(WATCHDOG_CLEAR_INSTR), .SLEEP_INSTR(SLEEP_INSTR),
    .WAKE_EVENT(WAKE_EVENT), .PRESC_ON_WDT(PRESC_ON_WDT), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .WDT_RESET(WDT_RESET), .WDT_WAKE(WDT_WAKE), .ASLEEP(ASLEEP),
    .PRESC_CLR(PRESC_CLR), .IRQ(IRQ));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask

  // A wait that runs out ends the run at once
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      $display("Error at %0t ns: wait ran out, seen %h expected %h", $time, n, lim);
      tally_and_finish();
    end
  endtask

  task automatic do_reset();
    @(posedge REF_CLK);
    RST_N <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
  endtask

  // One single word transfer; address held until ready, then data until ready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= wr;
    n = 0;
    do begin @(posedge REF_CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    guard(n, 50);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    n = 0;
    do begin @(posedge REF_CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    guard(n, 50);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  // Instruction pulse placed just after a tick, so the next pin edge starts the count
  task automatic instr(input logic slp);
    int n;
    n = 0;
    do begin @(posedge REF_CLK); n++; end while (osc_ph !== 3'h2 && n < 20);
    guard(n, 20);
    if (slp) SLEEP_INSTR <= 1'b1;
    else WATCHDOG_CLEAR_INSTR <= 1'b1;
    e0 = edges;
    @(posedge REF_CLK);
    SLEEP_INSTR <= 1'b0;
    WATCHDOG_CLEAR_INSTR <= 1'b0;
    #1;
    if (slp) chk(ASLEEP, 1'b1);
    else chk(PRESC_CLR, PRESC_ON_WDT);
  endtask

  // Pin edges from restart to the time-out pulse, and which pulse came
  task automatic meas(input logic [31:0] ticks, input logic [2:0] outs);
    int n;
    n = 0;
    do begin @(posedge REF_CLK); #1; n++; end
      while (WDT_RESET !== 1'b1 && WDT_WAKE !== 1'b1 && n < 5000);
    guard(n, 5000);
    chk(edges - e0, ticks);
    chk({WDT_WAKE, WDT_RESET, ASLEEP}, outs);
  endtask

  task automatic quiet(input int cyc);
    p0 = npulse;
    repeat (cyc) @(posedge REF_CLK);
    chk(npulse - p0, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 8; i++) begin
      do_reset();
      wr(`WDTPS_CFG_ADDR, rows[i].cfg);
      rdchk(`WDTPS_CFG_ADDR, rows[i].cfg);
      wr(`WDTPS_CTRL_ADDR, 32'h0);
      instr(1'b0);
      meas(rows[i].ticks, 3'b010);
      rdchk(`WDTPS_CAUSE_ADDR, 32'h4);
      rdchk(`WDTPS_ISTAT_ADDR, 32'h1);
    end
    // Reset values, with the oscillator held so nothing can fire
    osc_run <= 1'b0;
    do_reset();
    @(posedge REF_CLK);
    #1;
    chk({HREADYOUT, HRESP, WDT_RESET, WDT_WAKE, ASLEEP, PRESC_CLR, IRQ}, 32'h40);
    rdchk(`WDTPS_ISTAT_ADDR, 32'h0);
    rdchk(`WDTPS_CAUSE_ADDR, 32'hc);
    rdchk(`WDTPS_CTRL_ADDR, 32'h0);
    rdchk(`WDTPS_IMASK_ADDR, 32'h0);
    rdchk(`WDTPS_CFG_ADDR, 32'hf);
    wr(32'h0000_0040, 32'hffff_ffff);
    rdchk(32'h0000_0040, 32'h0);
    osc_run <= 1'b1;
    // Software enable only counts while the config enable is clear
    do_reset();
    wr(`WDTPS_CFG_ADDR, 32'he);
    wr(`WDTPS_CFG_ADDR, 32'hf);
    rdchk(`WDTPS_CFG_ADDR, 32'he);
    instr(1'b0);
    quiet(200);
    wr(`WDTPS_CTRL_ADDR, 32'h3);
    rdchk(`WDTPS_CTRL_ADDR, 32'h1);
    instr(1'b0);
    meas(BT, 3'b010);
    wr(`WDTPS_CTRL_ADDR, 32'h0);
    quiet(200);
    // Repeated clears hold off a running watchdog and clear the shared prescaler
    do_reset();
    PRESC_ON_WDT <= 1'b1;
    p0 = npulse;
    repeat (8) begin
      instr(1'b0);
      repeat (12) @(posedge REF_CLK);
    end
    chk(npulse - p0, 32'h0);
    PRESC_ON_WDT <= 1'b0;
    // Time-out in sleep wakes without reset; interrupt mask and clear
    do_reset();
    wr(`WDTPS_CFG_ADDR, 32'he);
    wr(`WDTPS_CTRL_ADDR, 32'h1);
    wr(`WDTPS_IMASK_ADDR, 32'h2);
    instr(1'b1);
    rdchk(`WDTPS_CAUSE_ADDR, 32'h8);
    meas(BT, 3'b100);
    wr(`WDTPS_CTRL_ADDR, 32'h0);
    rdchk(`WDTPS_CAUSE_ADDR, 32'h0);
    rdchk(`WDTPS_ISTAT_ADDR, 32'h2);
    chk(IRQ, 1'b1);
    wr(`WDTPS_IMASK_ADDR, 32'h0);
    @(posedge REF_CLK);
    #1;
    chk(IRQ, 1'b0);
    wr(`WDTPS_IMASK_ADDR, 32'h2);
    wr(`WDTPS_ISTAT_ADDR, 32'h2);
    @(posedge REF_CLK);
    #1;
    chk(IRQ, 1'b0);
    rdchk(`WDTPS_ISTAT_ADDR, 32'h0);
    // Another wake source ends sleep but leaves the sleep flags
    instr(1'b1);
    @(posedge REF_CLK);
    WAKE_EVENT <= 1'b1;
    @(posedge REF_CLK);
    WAKE_EVENT <= 1'b0;
    #1;
    chk(ASLEEP, 1'b0);
    rdchk(`WDTPS_CAUSE_ADDR, 32'h8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
